// ### rtl/gpio_port_consts.vh
// constants for the parallel i/o port with pin interrupt
`ifndef GPIO_PORT_CONSTS_VH
`define GPIO_PORT_CONSTS_VH

// port geometry
`define PORT_W 8
`define OUT_ONLY_MASK 8'h00

// register byte offsets
`define OFS_DATA 8'h00
`define OFS_DIR 8'h04
`define OFS_PULL 8'h08
`define OFS_SLEW 8'h0C
`define OFS_DRIVE 8'h10
`define OFS_IRQ_SEL 8'h14
`define OFS_IRQ_POL 8'h18
`define OFS_IRQ_SC 8'h1C

// register indices from decode
`define IDX_DATA 4'h0
`define IDX_DIR 4'h1
`define IDX_PULL 4'h2
`define IDX_SLEW 4'h3
`define IDX_DRIVE 4'h4
`define IDX_IRQ_SEL 4'h5
`define IDX_IRQ_POL 4'h6
`define IDX_IRQ_SC 4'h7
`define IDX_NONE 4'hF

// status/control field positions
`define SC_MODE_BIT 0
`define SC_IE_BIT 1
`define SC_ACK_BIT 2
`define SC_FLAG_BIT 3

// reset values
`define RST_DATA 8'h00
`define RST_DIR 8'h00
`define RST_PULL 8'h00
`define RST_SLEW 8'hFF
`define RST_DRIVE 8'h00
`define RST_IRQ_SEL 8'h00
`define RST_IRQ_POL 8'h00

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ### rtl/gpio_port.v
// parallel i/o port with pin controls, pin interrupt and axi4-lite registers
`timescale 1ns/1ns
`default_nettype none
`include "gpio_port_consts.vh"

module gpio_port (
  // clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // shared peripherals, same clock
  input wire [7:0] periph_en_i,
  input wire [7:0] periph_oe_i,
  input wire [7:0] periph_do_i,
  input wire [7:0] analog_en_i,
  // pins
  input wire [7:0] pin_i,
  output reg [7:0] pin_o,
  output reg [7:0] pin_oe_o,
  output reg [7:0] in_buf_en_o,
  output reg [7:0] periph_di_o,
  // pad controls
  output reg [7:0] pull_en_o,
  output reg [7:0] pull_down_o,
  output reg [7:0] slew_limit_o,
  output reg [7:0] drive_boost_o,
  // interrupt and wake
  output reg port_irq_o,
  output reg wake_o
);

  // byte offset to register index, used for reads and writes
  function [3:0] reg_index;
    input [7:0] addr;
    begin
      case (addr)
        `OFS_DATA: reg_index = `IDX_DATA;
        `OFS_DIR: reg_index = `IDX_DIR;
        `OFS_PULL: reg_index = `IDX_PULL;
        `OFS_SLEW: reg_index = `IDX_SLEW;
        `OFS_DRIVE: reg_index = `IDX_DRIVE;
        `OFS_IRQ_SEL: reg_index = `IDX_IRQ_SEL;
        `OFS_IRQ_POL: reg_index = `IDX_IRQ_POL;
        `OFS_IRQ_SC: reg_index = `IDX_IRQ_SC;
        default: reg_index = `IDX_NONE;
      endcase
    end
  endfunction

  // per-pin asserted level, sample equals polarity; analog pins never assert
  function [7:0] pin_asserted;
    input [7:0] sample;
    input [7:0] pol;
    input [7:0] live;
    begin
      pin_asserted = ~(sample ^ pol) & live;
    end
  endfunction

  // software registers
  reg [7:0] port_data;
  reg [7:0] pin_direction_bits;
  reg [7:0] pin_pull_enable_bits;
  reg [7:0] pin_slew_limit_bits;
  reg [7:0] pin_drive_boost_bits;
  reg [7:0] irq_pin_select_bits;
  reg [7:0] irq_polarity_bits;
  reg detect_level_mode_bit;
  reg port_irq_enable;
  reg port_irq_flag;

  // pin synchroniser and previous sample
  reg [7:0] pin_meta;
  reg [7:0] pin_sync;
  reg [7:0] pin_prev;

  // bus holding state
  reg aw_hold;
  reg w_hold;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // write fires once both halves are held and no response is pending
  wire do_write = aw_hold & w_hold & ~s_axi_bvalid_o;
  wire [3:0] wr_idx = reg_index(aw_addr);
  wire lane0 = do_write & w_strb[0];
  wire [3:0] rd_idx = reg_index(s_axi_araddr_i);

  // pin function arbitration
  wire [7:0] digital_own = periph_en_i & ~analog_en_i;
  wire [7:0] next_oe = ~analog_en_i &
    ((digital_own & periph_oe_i) | (~periph_en_i & pin_direction_bits));
  wire [7:0] next_out = (digital_own & periph_do_i) |
    (~periph_en_i & port_data);
  wire [7:0] next_in_buf = ~analog_en_i & ~`OUT_ONLY_MASK;
  wire [7:0] pin_level = pin_sync & next_in_buf;
  wire [7:0] data_read = (pin_direction_bits & port_data) |
    (~pin_direction_bits & pin_level);

  // detection: asserted when sample equals polarity
  wire [7:0] asserted_now = pin_asserted(pin_level, irq_polarity_bits, next_in_buf);
  wire [7:0] asserted_prev = pin_asserted(pin_prev, irq_polarity_bits, next_in_buf);
  wire [7:0] edge_hit = irq_pin_select_bits & ~asserted_prev & asserted_now;
  wire [7:0] level_hit = irq_pin_select_bits & asserted_now;
  wire irq_set = (|edge_hit) | (detect_level_mode_bit & (|level_hit));
  wire ack_wr = lane0 & (wr_idx == `IDX_IRQ_SC) & w_data[`SC_ACK_BIT];
  // set wins over ack; in level mode an asserted pin keeps flag set
  wire next_flag = irq_set | (port_irq_flag & ~ack_wr);

  // read mux
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    case (rd_idx)
      `IDX_DATA: next_rdata[7:0] = data_read;
      `IDX_DIR: next_rdata[7:0] = pin_direction_bits;
      `IDX_PULL: next_rdata[7:0] = pin_pull_enable_bits;
      `IDX_SLEW: next_rdata[7:0] = pin_slew_limit_bits;
      `IDX_DRIVE: next_rdata[7:0] = pin_drive_boost_bits;
      `IDX_IRQ_SEL: next_rdata[7:0] = irq_pin_select_bits;
      `IDX_IRQ_POL: next_rdata[7:0] = irq_polarity_bits;
      `IDX_IRQ_SC: begin
        next_rdata[`SC_MODE_BIT] = detect_level_mode_bit;
        next_rdata[`SC_IE_BIT] = port_irq_enable;
        next_rdata[`SC_FLAG_BIT] = port_irq_flag;
      end
      default: next_rdata = 32'h00000000;
    endcase
  end

  // two-flop pin synchroniser plus previous sample for edges
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
      pin_prev <= 8'h00;
    end else begin
      pin_meta <= pin_i;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // write address and data channels, taken in either order
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i & s_axi_awready_o) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i & s_axi_wready_o) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= (wr_idx == `IDX_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bvalid_o & s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // read channel
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `RESP_OKAY;
    end else if (s_axi_arvalid_i & s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= next_rdata;
      s_axi_rresp_o <= (rd_idx == `IDX_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rvalid_o & s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // register file, byte lane 0 carries all fields
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      port_data <= `RST_DATA;
      pin_direction_bits <= `RST_DIR;
      pin_pull_enable_bits <= `RST_PULL;
      pin_slew_limit_bits <= `RST_SLEW;
      pin_drive_boost_bits <= `RST_DRIVE;
      irq_pin_select_bits <= `RST_IRQ_SEL;
      irq_polarity_bits <= `RST_IRQ_POL;
      detect_level_mode_bit <= 1'b0;
      port_irq_enable <= 1'b0;
    end else if (lane0) begin
      case (wr_idx)
        `IDX_DATA: port_data <= w_data[7:0];
        `IDX_DIR: pin_direction_bits <= w_data[7:0];
        `IDX_PULL: pin_pull_enable_bits <= w_data[7:0];
        `IDX_SLEW: pin_slew_limit_bits <= w_data[7:0];
        `IDX_DRIVE: pin_drive_boost_bits <= w_data[7:0];
        `IDX_IRQ_SEL: irq_pin_select_bits <= w_data[7:0];
        `IDX_IRQ_POL: irq_polarity_bits <= w_data[7:0];
        `IDX_IRQ_SC: begin
          detect_level_mode_bit <= w_data[`SC_MODE_BIT];
          port_irq_enable <= w_data[`SC_IE_BIT];
        end
        default: port_data <= port_data;
      endcase
    end
  end

  // interrupt flag, request and wake
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      port_irq_flag <= 1'b0;
      port_irq_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      port_irq_flag <= next_flag;
      port_irq_o <= next_flag & port_irq_enable;
      wake_o <= next_flag;
    end
  end

  // registered pad controls
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pin_o <= 8'h00;
      pin_oe_o <= 8'h00;
      in_buf_en_o <= 8'h00;
      periph_di_o <= 8'h00;
      pull_en_o <= 8'h00;
      pull_down_o <= 8'h00;
      slew_limit_o <= 8'h00;
      drive_boost_o <= 8'h00;
    end else begin
      pin_o <= next_out;
      pin_oe_o <= next_oe;
      in_buf_en_o <= next_in_buf;
      periph_di_o <= pin_level;
      pull_en_o <= pin_pull_enable_bits & ~next_oe & ~analog_en_i;
      pull_down_o <= irq_pin_select_bits & irq_polarity_bits;
      slew_limit_o <= pin_slew_limit_bits & next_oe;
      drive_boost_o <= pin_drive_boost_bits & next_oe;
    end
  end

endmodule
`default_nettype wire

// ### verif/gpio_port_monitor.sv
// assertion checker for the parallel i/o port
`timescale 1ns/1ns
`default_nettype none
module gpio_port_monitor (
  // watched ports
  input wire clk_sys_i,
  input wire rst_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_bvalid_o,
  input wire [7:0] periph_en_i,
  input wire [7:0] periph_oe_i,
  input wire [7:0] analog_en_i,
  input wire [7:0] pin_oe_o,
  input wire [7:0] in_buf_en_o,
  input wire [7:0] periph_di_o,
  input wire [7:0] pull_en_o,
  input wire [7:0] slew_limit_o,
  input wire [7:0] drive_boost_o,
  input wire port_irq_o,
  input wire wake_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // read address taken, answer follows
  sequence ar_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  sequence r_hold;
    s_axi_rvalid_o && !s_axi_arready_o;
  endsequence
  chk_read_turn: assert property (ar_take |=> r_hold)
    else $error("read answer missing");
  chk_analog_off: assert property (((pin_oe_o | in_buf_en_o | periph_di_o)
    & $past(analog_en_i)) == 8'h00) else $error("analog pin buffer on");
  chk_inbuf_on: assert property (!$past(rst_i) |-> in_buf_en_o == ~$past(analog_en_i))
    else $error("input buffer wrong");
  chk_pull_out: assert property ((pull_en_o & (pin_oe_o | $past(analog_en_i))) == 8'h00)
    else $error("pull on driven pin");
  chk_pad_gate: assert property (((slew_limit_o | drive_boost_o) & ~pin_oe_o) == 8'h00)
    else $error("pad control on input");
  chk_periph_own: assert property (!$past(rst_i) |-> ((pin_oe_o ^ $past(periph_oe_i))
    & $past(periph_en_i & ~analog_en_i)) == 8'h00) else $error("peripheral enable ignored");
  chk_irq_gate: assert property (port_irq_o |-> wake_o)
    else $error("request without flag");
  chk_flag_clear: assert property ($fell(wake_o) |-> $rose(s_axi_bvalid_o))
    else $error("flag cleared without write");
endmodule
bind gpio_port gpio_port_monitor mon_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .periph_en_i(periph_en_i), .periph_oe_i(periph_oe_i), .analog_en_i(analog_en_i),
  .pin_oe_o(pin_oe_o), .in_buf_en_o(in_buf_en_o), .periph_di_o(periph_di_o),
  .pull_en_o(pull_en_o), .slew_limit_o(slew_limit_o), .drive_boost_o(drive_boost_o),
  .port_irq_o(port_irq_o), .wake_o(wake_o));
`default_nettype wire

// ### verif/pin_board.sv
// board model: external drivers, pulls and floating pins
`timescale 1ns/1ns
`default_nettype none
module pin_board (
  // pad side
  input wire clk_sys_i,
  input wire [7:0] pin_o,
  input wire [7:0] pin_oe_o,
  input wire [7:0] pull_en_o,
  input wire [7:0] pull_down_o,
  // board drivers
  input wire [7:0] ext_drv_i,
  input wire [7:0] ext_val_i,
  output logic [7:0] pin_lvl_o
);
  logic [7:0] flt = 8'h55;
  // a floating pin wanders every cycle
  always @(posedge clk_sys_i) flt <= ~flt;
  // wire level: port driver, board driver, pull resistor, else floating
  assign pin_lvl_o = (pin_oe_o & pin_o) | (~pin_oe_o & ext_drv_i & ext_val_i)
    | (~pin_oe_o & ~ext_drv_i & pull_en_o & ~pull_down_o)
    | (~pin_oe_o & ~ext_drv_i & ~pull_en_o & flt);
endmodule
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for the parallel i/o port
`timescale 1ns/1ns
`default_nettype none
`include "gpio_port_consts.vh"
module tb;
  logic clk_sys_i = 0, rst_i = 1, awvalid = 0, wvalid = 0, arvalid = 0;
  logic [7:0] awaddr = 0, araddr = 0, pen = 0, poe = 0, pdo = 0, aen = 0, edrv = 8'hFF, eval = 0;
  logic [3:0] wstrb = 4'hF;
  logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [31:0] wdata = 0;
  wire awready, wready, bvalid, arready, rvalid, irq, wake;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] pin, pin_o, pin_oe, pull_en, pull_dn, slew, drive, pdi;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int n_errors = 0, tests_run = 0, seed = 32'h3492594a;
  logic [7:0] v;
  gpio_port dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(1'b1), .periph_en_i(pen), .periph_oe_i(poe), .periph_do_i(pdo),
    .analog_en_i(aen), .pin_i(pin), .pin_o(pin_o), .pin_oe_o(pin_oe), .in_buf_en_o(),
    .periph_di_o(pdi), .pull_en_o(pull_en), .pull_down_o(pull_dn), .slew_limit_o(slew),
    .drive_boost_o(drive), .port_irq_o(irq), .wake_o(wake));
  pin_board brd_u (.clk_sys_i(clk_sys_i), .pin_o(pin_o), .pin_oe_o(pin_oe),
    .pull_en_o(pull_en), .pull_down_o(pull_dn), .ext_drv_i(edrv), .ext_val_i(eval),
    .pin_lvl_o(pin));
  // clock
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    int n;
    bq.push_back(r);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys_i);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    if (n == 40) begin n_errors++; stop_test; end
  endtask
  task rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys_i);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    if (n == 40) begin n_errors++; stop_test; end
  endtask
  // answers checked against the oldest note
  always @(posedge clk_sys_i) begin
    if (bvalid) chk("bresp", bresp, bq.pop_front());
    if (rvalid) chk("rdata", {rresp, rdata}, rq.pop_front());
  end
  initial begin
    tick(16);
    rst_i <= 0;
    foreach (rv[i]) rd(8'(i * 4), {26'h0, rv[i]});
    chk("pin_oe", pin_oe, 8'h00);
    chk("pin_o", pin_o, 8'h00);
    chk("pull_en", pull_en, 8'h00);
    rd(8'h20, {`RESP_SLVERR, 32'h0});
    wr(8'h24, 8'hFF, `RESP_SLVERR);
    v = 8'($random(seed));
    edrv <= 8'hF0;
    eval <= v;
    wr(`OFS_DATA, 8'hA5, `RESP_OKAY);
    wr(`OFS_DIR, 8'h0F, `RESP_OKAY);
    // a write with lane 0 strobe off must not land
    wstrb <= 4'h0;
    wr(`OFS_DIR, 8'hFF, `RESP_OKAY);
    wstrb <= 4'hF;
    wr(`OFS_DRIVE, 8'h03, `RESP_OKAY);
    tick(4);
    chk("pin_oe", pin_oe, 8'h0F);
    chk("pin_o", pin_o & 8'h0F, 8'h05);
    chk("slew", slew, 8'h0F);
    chk("drive", drive, 8'h03);
    rd(`OFS_DATA, {26'h0, v[7:4], 4'h5});
    // analog and peripheral ownership
    aen <= 8'h11;
    pen <= 8'h13;
    poe <= 8'h02;
    pdo <= 8'h02;
    wr(`OFS_PULL, 8'hFF, `RESP_OKAY);
    tick(3);
    chk("pin_oe", pin_oe, 8'h0E);
    chk("pull_en", pull_en, 8'hE0);
    chk("pin_o", pin_o, 8'hA6);
    chk("periph_di", pdi, {v[7:5], 5'h06});
    rd(`OFS_DATA, {26'h0, v[7:5], 5'h05});
    // edge mode, falling on pin 7, mask then acknowledge
    aen <= 8'h00;
    pen <= 8'h00;
    eval <= 8'h80;
    wr(`OFS_IRQ_SEL, 8'h80, `RESP_OKAY);
    wr(`OFS_IRQ_SC, 8'h04, `RESP_OKAY);
    wr(`OFS_IRQ_SC, 8'h02, `RESP_OKAY);
    eval <= 8'h00;
    tick(8);
    chk("irq", irq, 1'b1);
    wr(`OFS_IRQ_SC, 8'h00, `RESP_OKAY);
    rd(`OFS_IRQ_SC, {30'h0, 4'h8});
    chk("irq", irq, 1'b0);
    wr(`OFS_IRQ_SC, 8'h04, `RESP_OKAY);
    tick(2);
    chk("wake", wake, 1'b0);
    // level mode keeps the flag while asserted
    wr(`OFS_IRQ_SC, 8'h07, `RESP_OKAY);
    tick(2);
    rd(`OFS_IRQ_SC, {30'h0, 4'hB});
    wr(`OFS_IRQ_SC, 8'h07, `RESP_OKAY);
    chk("wake", wake, 1'b1);
    eval <= 8'h80;
    tick(6);
    wr(`OFS_IRQ_SC, 8'h07, `RESP_OKAY);
    tick(2);
    chk("irq", irq, 1'b0);
    // rising polarity with pull-down
    eval <= 8'h00;
    wr(`OFS_IRQ_POL, 8'h80, `RESP_OKAY);
    edrv <= 8'h70;
    wr(`OFS_IRQ_SC, 8'h06, `RESP_OKAY);
    tick(2);
    chk("pull_dn", pull_dn[7], 1'b1);
    rd(`OFS_IRQ_SC, {30'h0, 4'h2});
    edrv <= 8'hF0;
    eval <= 8'h80;
    tick(8);
    rd(`OFS_IRQ_SC, {30'h0, 4'hA});
    tick(2);
    stop_test;
  end
endmodule
`default_nettype wire
